// *** verilog/scem_defines.vh ***
// constants of the serial command and error monitor block
// assumes a 16-bit frame, msb first, even parity in bit 0
`ifndef SCEM_DEFINES_VH
`define SCEM_DEFINES_VH

// ************************************************************
// frame layout
// ************************************************************
`define SCEM_FRAME_BITS 16
`define SCEM_CNT_W 5
`define SCEM_CNT_FULL 5'h10
`define SCEM_BIT_RW 15
`define SCEM_ADDR_HI 14
`define SCEM_ADDR_LO 1
`define SCEM_BIT_RESSEL 2
`define SCEM_NOP_WORD 16'h0000
`define SCEM_DATA_ZERO 14'h0000

// ************************************************************
// command addresses
// ************************************************************
`define SCEM_ADDR_STATUS 14'h335a
`define SCEM_ADDR_CLEAR 14'h3380
`define SCEM_ADDR_SWRESET 14'h3c00
`define SCEM_ADDR_ANGLE 14'h3fff

// ************************************************************
// error status word
// ************************************************************
`define SCEM_STATUS_W 14
`define SCEM_STATUS_RST 14'h0000
`define SCEM_ST_PARITY 0
`define SCEM_ST_CLOCK 1
`define SCEM_ST_ADDR 2
`define SCEM_ST_WATCH 4
`define SCEM_ST_MODE 5
`define SCEM_ST_FIELD 8
`define SCEM_ST_ROTATOR 9
`define SCEM_ST_BIAS 10
`define SCEM_ST_GAIN_LO 11
`define SCEM_ST_GAIN_HI 12

// ************************************************************
// misc
// ************************************************************
`define SCEM_ANGLE_W 12
`define SCEM_SETTLE_W 2
`define SCEM_SETTLE_DONE 2'h3

`endif

// *** verilog/scem_frame_shift.v ***
// serial shifter and edge counter for one frame
// assumes sample and shift enables are one-cycle pulses on one clock
`timescale 1ns/1ps
`default_nettype none

module scem_frame_shift #(
    parameter WIDTH = 16,
    parameter CNT_W = 5
) (
    input wire clk,
    input wire rst_n,
    input wire start,
    input wire sample_en,
    input wire shift_en,
    input wire din,
    input wire [WIDTH-1:0] load_word,
    output reg [WIDTH-1:0] rx_word,
    output reg dout,
    output reg [CNT_W-1:0] count
);

reg [WIDTH-1:0] tx_word;

always @(posedge clk)
begin
    if (!rst_n)
    begin
        rx_word <= {WIDTH{1'b0}};
        tx_word <= {WIDTH{1'b0}};
        dout <= 1'b0;
        count <= {CNT_W{1'b0}};
    end
    else if (start)
    begin
        tx_word <= load_word;
        count <= {CNT_W{1'b0}};
    end
    else
    begin
        if (shift_en)
        begin
            dout <= tx_word[WIDTH-1];
            tx_word <= {tx_word[WIDTH-2:0], 1'b0};
        end
        if (sample_en)
        begin
            rx_word <= {rx_word[WIDTH-2:0], din};
            // saturate so a runaway clock still reads as too many
            if (count != {CNT_W{1'b1}})
                count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end
end

endmodule // scem_frame_shift

`default_nettype wire

// *** verilog/scem_top.v ***
// serial slave command interface with error monitor
// assumes the angle datapath, oscillator and fuse store sit outside
`include "scem_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module scem_top (
    input wire MCLK,
    input wire RST_N,
    input wire SCK,
    input wire SS_N,
    input wire MOSI,
    input wire WIRE_MODE,
    output wire MISO,
    output reg MISO_OE_N,
    input wire [`SCEM_ANGLE_W-1:0] ANGLE_DATA,
    input wire MEAS_DONE,
    input wire MEAS_BUSY,
    input wire SLEEPING,
    input wire OSC_READY,
    input wire FIELD_OVERRANGE,
    input wire ROTATOR_OVERFLOW,
    input wire BIAS_RANGE_FAULT,
    input wire GAIN_LOW_ALARM,
    input wire GAIN_HIGH_ALARM,
    output reg MEAS_START,
    output reg SOFT_RESET,
    output reg OTP_LOAD,
    output reg OSC_START,
    output reg WIRE_MODE_4W,
    output reg TRANSFER_FAULT_FLAG,
    output reg [`SCEM_STATUS_W-1:0] ERROR_STATUS_FLAGS
);

// ************************************************************
// pin synchronisers and edge detection
// ************************************************************
reg sck_s1, sck_s2, sck_s3;
reg ss_s1, ss_s2, ss_s3;
reg mosi_s1, mosi_s2;
reg wm_s1, wm_s2;

always @(posedge MCLK)
begin
    if (!RST_N)
    begin
        sck_s1 <= 1'b0;
        sck_s2 <= 1'b0;
        sck_s3 <= 1'b0;
        ss_s1 <= 1'b1;
        ss_s2 <= 1'b1;
        ss_s3 <= 1'b1;
        mosi_s1 <= 1'b0;
        mosi_s2 <= 1'b0;
        wm_s1 <= 1'b1;
        wm_s2 <= 1'b1;
    end
    else
    begin
        sck_s1 <= SCK;
        sck_s2 <= sck_s1;
        sck_s3 <= sck_s2;
        ss_s1 <= SS_N;
        ss_s2 <= ss_s1;
        ss_s3 <= ss_s2;
        mosi_s1 <= MOSI;
        mosi_s2 <= mosi_s1;
        wm_s1 <= WIRE_MODE;
        wm_s2 <= wm_s1;
    end
end

wire active = !ss_s2;
wire frame_start = ss_s3 && !ss_s2;
wire frame_end = !ss_s3 && ss_s2;
wire sck_fall = active && sck_s3 && !sck_s2;
wire sck_rise = active && !sck_s3 && sck_s2;

// ************************************************************
// shifter
// ************************************************************
reg [`SCEM_FRAME_BITS-1:0] resp_word;
wire [`SCEM_FRAME_BITS-1:0] rx_word;
wire [`SCEM_CNT_W-1:0] edge_count;

// full duplex, msb first; the answer loaded here was built last frame
scem_frame_shift #(
    .WIDTH(`SCEM_FRAME_BITS),
    .CNT_W(`SCEM_CNT_W)
) u_shift (
    .clk(MCLK),
    .rst_n(RST_N),
    .start(frame_start),
    .sample_en(sck_fall),
    .shift_en(sck_rise),
    .din(mosi_s2),
    .load_word(resp_word),
    .rx_word(rx_word),
    .dout(MISO),
    .count(edge_count)
);

// ************************************************************
// frame decode
// ************************************************************
wire [`SCEM_ADDR_HI-`SCEM_ADDR_LO:0] addr =
    rx_word[`SCEM_ADDR_HI:`SCEM_ADDR_LO];
wire is_read = rx_word[`SCEM_BIT_RW];
wire par_bad = ^rx_word;
wire cnt_bad = edge_count != `SCEM_CNT_FULL;
wire is_nop = rx_word == `SCEM_NOP_WORD;
wire rd_status = is_read && addr == `SCEM_ADDR_STATUS;
wire rd_clear = is_read && addr == `SCEM_ADDR_CLEAR;
wire rd_angle = is_read && addr == `SCEM_ADDR_ANGLE;
wire wr_reset = !is_read && addr == `SCEM_ADDR_SWRESET;
reg data_pending;
// 3-wire links cannot send commands, so every frame without a parity or count error reads the angle
wire three_wire = !WIRE_MODE_4W;
wire addr_bad = !three_wire && !data_pending && !is_nop &&
    !(rd_status || rd_clear || rd_angle || wr_reset);
wire frame_bad = par_bad || cnt_bad || addr_bad;
wire exec = frame_end && !frame_bad;

function [`SCEM_FRAME_BITS-1:0] scem_frame;
    input [`SCEM_STATUS_W-1:0] data;
    input flag;
    begin
        scem_frame = {data, flag, ^{data, flag}};
    end
endfunction

wire any_error = TRANSFER_FAULT_FLAG ||
    (ERROR_STATUS_FLAGS != `SCEM_STATUS_RST);
// alarm pair: 11 overrides the gain state when any error stands
wire frame_gain_high_bit = any_error || GAIN_HIGH_ALARM;
wire frame_gain_low_bit = any_error || (GAIN_LOW_ALARM && !GAIN_HIGH_ALARM);
wire [`SCEM_STATUS_W-1:0] angle_data =
    {frame_gain_high_bit, frame_gain_low_bit, ANGLE_DATA};

// ************************************************************
// reset sequencer
// ************************************************************
localparam ST_IDLE = 3'h0;
localparam ST_WAKE = 3'h1;
localparam ST_FIRE = 3'h2;
localparam ST_LOAD = 3'h3;
localparam ST_CONV = 3'h4;

reg [2:0] state;
reg [2:0] next_state;
reg reset_iface;
reg [`SCEM_SETTLE_W-1:0] settle;
wire sched_reset = exec && data_pending;

always @*
begin
    next_state = state;
    case (state)
        ST_IDLE:
            if (sched_reset)
                next_state = SLEEPING ? ST_WAKE : ST_FIRE;
        ST_WAKE:
            if (OSC_READY)
                next_state = ST_FIRE;
        ST_FIRE:
            next_state = ST_LOAD;
        ST_LOAD:
            if (settle == `SCEM_SETTLE_DONE)
                next_state = ST_CONV;
        ST_CONV:
            next_state = ST_IDLE;
        default:
            next_state = ST_IDLE;
    endcase
end

always @(posedge MCLK)
begin
    if (!RST_N)
    begin
        // power-on starts straight in the fuse load
        state <= ST_LOAD;
        settle <= {`SCEM_SETTLE_W{1'b0}};
        reset_iface <= 1'b0;
        OSC_START <= 1'b0;
        SOFT_RESET <= 1'b0;
        OTP_LOAD <= 1'b0;
        WIRE_MODE_4W <= 1'b1;
    end
    else
    begin
        state <= next_state;
        OSC_START <= state == ST_IDLE && next_state == ST_WAKE;
        SOFT_RESET <= state == ST_FIRE;
        OTP_LOAD <= state == ST_LOAD &&
            settle == `SCEM_SETTLE_DONE;
        if (sched_reset)
            reset_iface <= rx_word[`SCEM_BIT_RESSEL];
        if (state == ST_LOAD)
            settle <= settle + {{(`SCEM_SETTLE_W-1){1'b0}}, 1'b1};
        else
            settle <= {`SCEM_SETTLE_W{1'b0}};
        // settle gives the pin synchroniser time after power-up
        if (state == ST_LOAD && settle == `SCEM_SETTLE_DONE)
            WIRE_MODE_4W <= wm_s2;
    end
end

wire iface_clear = state == ST_FIRE && reset_iface;

// ************************************************************
// flags, status and response
// ************************************************************
always @(posedge MCLK)
begin
    if (!RST_N)
    begin
        TRANSFER_FAULT_FLAG <= 1'b0;
        ERROR_STATUS_FLAGS <= `SCEM_STATUS_RST;
        resp_word <= `SCEM_NOP_WORD;
        data_pending <= 1'b0;
        MEAS_START <= 1'b0;
        MISO_OE_N <= 1'b1;
    end
    else
    begin
        MISO_OE_N <= !active;
        MEAS_START <= (exec && !data_pending &&
            (rd_angle || three_wire)) || state == ST_CONV;
        ERROR_STATUS_FLAGS[`SCEM_ST_MODE] <= MEAS_BUSY;
        ERROR_STATUS_FLAGS[`SCEM_ST_FIELD] <= FIELD_OVERRANGE;
        ERROR_STATUS_FLAGS[`SCEM_ST_ROTATOR] <= ROTATOR_OVERFLOW;
        ERROR_STATUS_FLAGS[`SCEM_ST_BIAS] <= BIAS_RANGE_FAULT;
        ERROR_STATUS_FLAGS[`SCEM_ST_GAIN_LO] <= GAIN_LOW_ALARM;
        ERROR_STATUS_FLAGS[`SCEM_ST_GAIN_HI] <= GAIN_HIGH_ALARM;
        if (exec && !data_pending && (rd_angle || three_wire))
            ERROR_STATUS_FLAGS[`SCEM_ST_WATCH] <= 1'b1;
        else if (MEAS_DONE)
            ERROR_STATUS_FLAGS[`SCEM_ST_WATCH] <= 1'b0;
        if (iface_clear)
        begin
            TRANSFER_FAULT_FLAG <= 1'b0;
            ERROR_STATUS_FLAGS[`SCEM_ST_PARITY] <= 1'b0;
            ERROR_STATUS_FLAGS[`SCEM_ST_CLOCK] <= 1'b0;
            ERROR_STATUS_FLAGS[`SCEM_ST_ADDR] <= 1'b0;
            resp_word <= `SCEM_NOP_WORD;
            data_pending <= 1'b0;
        end
        else if (frame_end)
        begin
            if (frame_bad)
            begin
                // flag sticks until an explicit clear
                TRANSFER_FAULT_FLAG <= 1'b1;
                if (par_bad)
                    ERROR_STATUS_FLAGS[`SCEM_ST_PARITY] <= 1'b1;
                if (cnt_bad)
                    ERROR_STATUS_FLAGS[`SCEM_ST_CLOCK] <= 1'b1;
                if (addr_bad)
                    ERROR_STATUS_FLAGS[`SCEM_ST_ADDR] <= 1'b1;
                data_pending <= 1'b0;
                resp_word <= scem_frame(`SCEM_DATA_ZERO, 1'b1);
            end
            else if (data_pending)
            begin
                data_pending <= 1'b0;
                resp_word <= scem_frame(rx_word[`SCEM_ADDR_HI:
                    `SCEM_ADDR_LO], TRANSFER_FAULT_FLAG);
            end
            else if (three_wire || rd_angle)
                resp_word <= scem_frame(angle_data,
                    TRANSFER_FAULT_FLAG);
            else if (rd_clear)
            begin
                // clear is only reachable in 4-wire mode
                TRANSFER_FAULT_FLAG <= 1'b0;
                ERROR_STATUS_FLAGS[`SCEM_ST_PARITY] <= 1'b0;
                ERROR_STATUS_FLAGS[`SCEM_ST_CLOCK] <= 1'b0;
                ERROR_STATUS_FLAGS[`SCEM_ST_ADDR] <= 1'b0;
                resp_word <= `SCEM_NOP_WORD;
            end
            else if (rd_status)
                resp_word <= scem_frame(ERROR_STATUS_FLAGS,
                    TRANSFER_FAULT_FLAG);
            else if (wr_reset)
            begin
                data_pending <= 1'b1;
                resp_word <= scem_frame(`SCEM_DATA_ZERO,
                    TRANSFER_FAULT_FLAG);
            end
            else
                resp_word <= scem_frame(`SCEM_DATA_ZERO,
                    TRANSFER_FAULT_FLAG);
        end
    end
end

endmodule // scem_top

`default_nettype wire

// *** verification/scem_assertions.sv ***
// port checks for the serial command and error monitor
// assumes bind onto scem_top, all in the MCLK domain
`include "scem_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module scem_assertions (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic SS_N,
    input wire logic MISO_OE_N,
    input wire logic MEAS_BUSY,
    input wire logic FIELD_OVERRANGE,
    input wire logic ROTATOR_OVERFLOW,
    input wire logic BIAS_RANGE_FAULT,
    input wire logic GAIN_LOW_ALARM,
    input wire logic GAIN_HIGH_ALARM,
    input wire logic MEAS_START,
    input wire logic SOFT_RESET,
    input wire logic OTP_LOAD,
    input wire logic TRANSFER_FAULT_FLAG,
    input wire logic [`SCEM_STATUS_W-1:0] ERROR_STATUS_FLAGS
);
    wire [4:0] dsp_in;
    assign dsp_in = {GAIN_HIGH_ALARM, GAIN_LOW_ALARM, BIAS_RANGE_FAULT,
        ROTATOR_OVERFLOW, FIELD_OVERRANGE};

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    // *****
    // sequences
    // *****
    // fuse reload, then the fresh conversion start
    sequence s_reload;
        ##[1:10] OTP_LOAD ##1 MEAS_START;
    endsequence
    sequence s_idle;
        SS_N [*5];
    endsequence

    AST_RST_ZERO: assert property (
        $rose(RST_N) |-> !TRANSFER_FAULT_FLAG && ERROR_STATUS_FLAGS == 0)
        else $error("flag or status not clear after reset");
    AST_FLAG_HOLD: assert property (
        $fell(TRANSFER_FAULT_FLAG) && $past(RST_N) |-> SS_N)
        else $error("fault flag dropped inside a frame");
    AST_OE_OFF: assert property (s_idle |-> MISO_OE_N)
        else $error("output driven while deselected");
    AST_OE_ON: assert property (!SS_N [*5] |-> !MISO_OE_N)
        else $error("output not driven while selected");
    AST_RSVD: assert property (
        {ERROR_STATUS_FLAGS[13], ERROR_STATUS_FLAGS[7:6],
        ERROR_STATUS_FLAGS[3]} == 4'h0)
        else $error("reserved status bit set");
    AST_DSP_LIVE: assert property (
        $past(RST_N) && !$past(SOFT_RESET)
        |-> ERROR_STATUS_FLAGS[12:8] == $past(dsp_in))
        else $error("dsp status bits do not follow inputs");
    AST_MODE: assert property (
        $past(RST_N) && !$past(SOFT_RESET)
        |-> ERROR_STATUS_FLAGS[5] == $past(MEAS_BUSY))
        else $error("busy status bit wrong");
    AST_PWR_LOAD: assert property ($rose(RST_N) |-> s_reload)
        else $error("no fuse load after power-on");
    AST_SW_LOAD: assert property (SOFT_RESET |-> s_reload)
        else $error("no fuse load after soft reset");
    AST_SR_IDLE: assert property (SOFT_RESET |-> SS_N)
        else $error("soft reset inside a frame");
endmodule // scem_assertions

bind scem_top scem_assertions u_scem_assertions (
    .MCLK(MCLK), .RST_N(RST_N), .SS_N(SS_N), .MISO_OE_N(MISO_OE_N),
    .MEAS_BUSY(MEAS_BUSY), .FIELD_OVERRANGE(FIELD_OVERRANGE),
    .ROTATOR_OVERFLOW(ROTATOR_OVERFLOW),
    .BIAS_RANGE_FAULT(BIAS_RANGE_FAULT), .GAIN_LOW_ALARM(GAIN_LOW_ALARM),
    .GAIN_HIGH_ALARM(GAIN_HIGH_ALARM), .MEAS_START(MEAS_START),
    .SOFT_RESET(SOFT_RESET), .OTP_LOAD(OTP_LOAD),
    .TRANSFER_FAULT_FLAG(TRANSFER_FAULT_FLAG),
    .ERROR_STATUS_FLAGS(ERROR_STATUS_FLAGS)
);

`default_nettype wire

// *** verification/scem_spi_master.sv ***
// behavioural serial master driving one frame per call
// assumes sck idles low and stands still between frames
`timescale 1ns/1ps
`default_nettype none

module scem_spi_master (
    output logic sck,
    output logic ss_n,
    output logic mosi,
    input wire logic miso,
    input wire logic miso_oe_n,
    output logic [15:0] rx_word,
    output logic rx_valid
);
    logic miso_w;
    // a released line shows the inverse, never a stale copy
    assign miso_w = miso_oe_n ? ~miso : miso;

    initial
    begin
        sck = 0;
        ss_n = 1;
        mosi = 0;
        rx_word = 0;
        rx_valid = 0;
    end

    task automatic xfer(input logic [15:0] tx, input int n);
        int i;
        ss_n = 0;
        #30;
        for (i = 0; i < n; i++)
        begin
            mosi = tx[15 - i % 16];
            sck = 1;
            #24;
            rx_word = {rx_word[14:0], miso_w};
            sck = 0;
            #24;
        end
        mosi = ~mosi;
        ss_n = 1;
        rx_valid = 1;
        #50;
        rx_valid = 0;
        #40;
    endtask
endmodule // scem_spi_master

`default_nettype wire

// *** verification/scem_top_tb.sv ***
// self-checking bench for the serial command and error monitor
// assumes the master model and the bound checker
`include "scem_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module scem_top_tb;
    logic mclk, sck, ss_n, mosi, miso, oe_n, rxv, mstart, srst, otp;
    logic oscst, w4, flag;
    logic rst_n = 0, wmode = 1, done = 0, busy = 0, sleep = 0, osc_rdy = 1;
    logic [`SCEM_ANGLE_W-1:0] angle = 0;
    logic [4:0] dsp = 0;
    logic [`SCEM_STATUS_W-1:0] st;
    logic [15:0] rx;
    logic [31:0] seed, m;
    logic [31:0] q[$];
    logic [15:0] ftx[4] = '{16'he6b4, 16'h0000, 16'h0000, 16'h8002};
    logic [2:0] fb[4] = '{3'h1, 3'h2, 3'h2, 3'h4};
    int fn[4] = '{16, 15, 17, 16};
    int fails = 0, checks_done = 0, cyc = 0, n_osc = 0, n_sr = 0, i, k;

    scem_top u_scem_top (
        .MCLK(mclk), .RST_N(rst_n), .SCK(sck), .SS_N(ss_n), .MOSI(mosi),
        .WIRE_MODE(wmode), .MISO(miso), .MISO_OE_N(oe_n),
        .ANGLE_DATA(angle), .MEAS_DONE(done), .MEAS_BUSY(busy),
        .SLEEPING(sleep), .OSC_READY(osc_rdy),
        .FIELD_OVERRANGE(dsp[0]), .ROTATOR_OVERFLOW(dsp[1]),
        .BIAS_RANGE_FAULT(dsp[2]), .GAIN_LOW_ALARM(dsp[3]),
        .GAIN_HIGH_ALARM(dsp[4]), .MEAS_START(mstart), .SOFT_RESET(srst),
        .OTP_LOAD(otp), .OSC_START(oscst), .WIRE_MODE_4W(w4),
        .TRANSFER_FAULT_FLAG(flag), .ERROR_STATUS_FLAGS(st)
    );
    scem_spi_master u_scem_spi_master (
        .sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso),
        .miso_oe_n(oe_n), .rx_word(rx), .rx_valid(rxv)
    );

    // *****
    // helpers
    // *****
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // even parity over the upper fifteen bits
    function automatic logic [15:0] fr(input logic [15:0] x);
        fr = {x[15:1], ^x[15:1]};
    endfunction
    function automatic logic [15:0] rsp(input logic [13:0] d, input logic f);
        rsp = {d, f, ^{d, f}};
    endfunction
    function automatic logic [13:0] stat(input logic [2:0] s);
        stat = {1'b0, dsp, 2'b00, busy, 2'b00, s};
    endfunction
    task automatic chk(input string nm, input logic [15:0] got, exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // the answer seen in this frame belongs to the previous command
    task automatic frm(input logic [15:0] tx, msk, ex, input int n = 16);
        q.push_back({msk, ex & msk});
        u_scem_spi_master.xfer(tx, n);
    endtask
    task test_done;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        mclk = 0;
        forever #2.5 mclk = ~mclk;
    end

    always @(posedge rxv)
    begin
        m = q.pop_front();
        chk("miso", rx & m[31:16], m[15:0]);
    end

    always @(posedge mclk)
    begin
        cyc++;
        n_osc += oscst;
        n_sr += srst;
        if (cyc == 20000)
        begin
            fails++;
            test_done();
        end
    end

    // *****
    // tests
    // *****
    initial
    begin
        seed = 32'h1cfd3641;
        tk(12);
        rst_n = 1;
        tk(20);
        chk("flag", flag, 0);
        chk("status", st, 0);
        chk("wire4", w4, 1);
        frm(16'h0000, 0, 0);
        frm(16'h0000, 16'hffff, 16'h0000);
        $display("test reset_nop done");
        repeat (3)
        begin
            tk(1);
            seed = lfsr(seed);
            {busy, dsp, angle} = seed[17:0];
            tk(2);
            frm(fr(16'he6b4), 0, 0);
            frm(16'h0000, 16'hffff, rsp(stat(0), 0));
        end
        $display("test status_read done");
        for (k = 0; k < 4; k++)
        begin
            frm(ftx[k], 0, 0, fn[k]);
            frm(fr(16'he6b4), 16'hffff, 16'h0003);
            frm(16'h0000, 16'hffff, rsp(stat(fb[k]), 1));
            chk("flag", flag, 1);
            frm(fr(16'he700), 0, 0);
            frm(16'h0000, 16'hffff, 16'h0000);
            chk("flag", flag, 0);
        end
        $display("test faults done");
        // a standing field fault makes the alarm pair read 11
        dsp = 5'h01;
        frm(16'hffff, 0, 0);
        chk("watch", st[4], 1);
        frm(16'h0000, 16'hffff, rsp({2'b11, angle}, 0));
        tk(1);
        done = 1;
        tk(2);
        done = 0;
        tk(2);
        chk("watch", st[4], 0);
        $display("test angle done");
        frm(16'hb35a, 0, 0);
        tk(1);
        sleep = 1;
        osc_rdy = 0;
        wmode = 0;
        frm(fr(16'h7800), 0, 0);
        frm(fr(16'h0004), 0, 0);
        tk(4);
        chk("osc", n_osc, 1);
        chk("early", n_sr, 0);
        chk("held", flag, 1);
        osc_rdy = 1;
        for (i = 0; i < 200 && n_sr == 0; i++) tk(1);
        tk(12);
        chk("sreset", n_sr, 1);
        chk("flag", flag, 0);
        chk("spibits", st[2:0], 0);
        chk("wire4", w4, 0);
        $display("test soft_reset done");
        test_done();
    end
endmodule // scem_top_tb

`default_nettype wire
